/* File: src/sscs_pkg.sv */
/*
  constants, offsets, field positions and helper functions for the system and
  slow clock select block.
  assumes a single 10 MHz core clock and a plain strobe register port.
*/
package sscs_pkg;
  // core clock
  localparam int unsigned CLK_HZ = 10_000_000;
  // slow crystal may need up to this long to settle (longest time, rounds down)
  localparam int unsigned SLOW_XTAL_STAB_S = 1;
  localparam int unsigned SLOW_XTAL_WAIT_CYC_DEF = SLOW_XTAL_STAB_S * CLK_HZ;
  // fast crystal typical settle time in microseconds
  localparam int unsigned XTAL32M_STAB_US = 1000;
  localparam int unsigned XTAL32M_SETTLE_CYC_DEF = (XTAL32M_STAB_US * (CLK_HZ / 1_000_000));
  localparam int unsigned CNT_W = 24;

  // register byte offsets
  localparam logic [7:0] OFF_SYS_CTRL = 8'h00;
  localparam logic [7:0] OFF_SLOW_SEL = 8'h04;
  localparam logic [7:0] OFF_SLOW_TRIM = 8'h08;
  localparam logic [7:0] OFF_CPU_DIV = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;

  // sys_ctrl fields
  localparam int unsigned BIT_SRC_IS_RC = 0;
  localparam int unsigned BIT_PWR_DOWN_OPT = 1;
  localparam int unsigned BIT_AUTO_SWITCH = 2;
  // status fields
  localparam int unsigned BIT_ST_SRC_IS_RC = 0;
  localparam int unsigned BIT_ST_XTAL_STABLE = 1;
  localparam int unsigned BIT_ST_SLOW_FAIL = 2;
  localparam int unsigned BIT_ST_DIV_FAIL = 3;
  localparam int unsigned BIT_ST_SLOW_TIMEOUT = 4;
  localparam int unsigned BIT_ST_SLOW_READY = 10;

  // slow clock source codes
  localparam logic [1:0] SLOW_SRC_INT_RC = 2'h0;
  localparam logic [1:0] SLOW_SRC_EXT_RC_MODULE = 2'h1;
  localparam logic [1:0] SLOW_SRC_EXT_CRYSTAL = 2'h2;

  // slow rc current trim codes
  localparam logic [2:0] TRIM_0U53 = 3'h2;
  localparam logic [2:0] TRIM_0U35 = 3'h3;

  // cpu divisor codes
  localparam logic [2:0] DIV_CODE_BY8 = 3'h0;
  localparam logic [2:0] DIV_CODE_BY4 = 3'h1;
  localparam logic [2:0] DIV_CODE_BY2 = 3'h2;
  localparam logic [2:0] DIV_CODE_BY1 = 3'h3;
  localparam logic [2:0] DIV_CODE_BAD4 = 3'h4;
  localparam logic [2:0] DIV_CODE_BAD5 = 3'h5;
  localparam logic [2:0] DIV_CODE_BY32 = 3'h6;
  localparam logic [2:0] DIV_CODE_BY16 = 3'h7;

  // system clock source state, one-hot
  typedef enum logic [2:0] {
    SRC_ON_RC = 3'h1,
    SRC_WAIT_XTAL = 3'h2,
    SRC_ON_XTAL = 3'h4
  } sscs_src_state_t;

  // true for the six legal divisor codes
  function automatic logic div_code_valid(input logic [2:0] code);
    div_code_valid = (code != DIV_CODE_BAD4) && (code != DIV_CODE_BAD5);
  endfunction

  // divide ratio for a legal code; illegal codes fall back to 2
  function automatic logic [5:0] div_ratio(input logic [2:0] code);
    unique case (code)
      DIV_CODE_BY8: div_ratio = 6'h08;
      DIV_CODE_BY4: div_ratio = 6'h04;
      DIV_CODE_BY1: div_ratio = 6'h01;
      DIV_CODE_BY32: div_ratio = 6'h20;
      DIV_CODE_BY16: div_ratio = 6'h10;
      default: div_ratio = 6'h02;
    endcase
  endfunction
endpackage

/* File: src/sscs_cpu_div.sv */
/*
  cpu and peripheral clock enable generator with glitch-free switching.
  assumes the core clock stands for the selected system source; new source and
  divisor are taken only at the end of a whole cpu period.
*/
`timescale 1ns/10ps
module sscs_cpu_div (
  input wire logic core_clk_in, // core clock
  input wire logic rst_in, // sync reset, active high
  input wire logic src_is_rc_in, // wanted source, 1 = rc
  input wire logic [2:0] div_code_in, // wanted cpu divisor code
  output logic src_is_rc_out, // source actually in use
  output logic cpu_clk_en_out, // one pulse per cpu clock period
  output logic periph_clk_en_out // one pulse every second source cycle
);
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic [5:0] ratio;
  logic [5:0] next_ratio;
  logic next_src;
  logic next_cpu_en;
  logic next_periph_en;

  // swap source and ratio only at period end, so no short pulse appears
  always_comb begin
    next_cnt = cnt + 5'h01;
    next_ratio = ratio;
    next_src = src_is_rc_out;
    next_cpu_en = 1'b0;
    next_periph_en = ~periph_clk_en_out; // source over two
    if ({1'b0, cnt} == ratio - 6'h01) begin
      next_cnt = 5'h00;
      next_cpu_en = 1'b1;
      next_ratio = sscs_pkg::div_ratio(div_code_in);
      next_src = src_is_rc_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cnt <= 5'h00;
      ratio <= 6'h02;
      src_is_rc_out <= 1'b1;
      cpu_clk_en_out <= 1'b0;
      periph_clk_en_out <= 1'b0;
    end else begin
      cnt <= next_cnt;
      ratio <= next_ratio;
      src_is_rc_out <= next_src;
      cpu_clk_en_out <= next_cpu_en;
      periph_clk_en_out <= next_periph_en;
    end
  end
endmodule

/* File: src/sscs_ctrl.sv */
/*
  system and slow clock select: slow 32 kHz source choice and rc trim, system
  source choice between fast crystal and high-speed rc, crystal power, cpu
  divisor with sleep default, and a small register port.
  assumes oscillators report stability as levels synchronous to core_clk_in,
  and sleep_in is a level that is high while the device sleeps.
*/
`timescale 1ns/10ps
// Overview of operation
// - slow source accepts external rc module or crystal; other codes flag failure
// - crystal start request starts it at once; settling may take one second
// - slow clock comes from internal rc until an external source is chosen and, for the crystal, stable
// - after an external slow source, return to internal rc is ignored
// - choosing the slow crystal forces both its pins to input, pulls off
// - trim code 2 is 0.53uA default, 3 is 0.35uA, others unchanged
// - system clock comes from fast crystal or high-speed rc
// - peripheral clock is the system source divided by two
// - source select bit one picks rc, zero picks crystal
// - with rc and power-down option, crystal is powered down
// - crystal selected but not running is powered up, switch waits stability
// - readable status tells rc or crystal, nothing on calibration
// - divisor codes map 0:8 1:4 2:2 3:1 6:32 7:16
// - divisor codes 4 and 5 rejected, old divisor kept, failure flagged
// - waking from sleep sets cpu divisor back to two
// - divisor reads back as the same three-bit code
// - after reset or wake, move to crystal once it is stable
// - readable status says whether the fast crystal runs and is stable
// - status bit 10 reads one once the slow clock is ready
module sscs_ctrl #(
  parameter int unsigned SLOW_XTAL_WAIT_CYC = sscs_pkg::SLOW_XTAL_WAIT_CYC_DEF,
  parameter int unsigned XTAL_SETTLE_CYC = sscs_pkg::XTAL32M_SETTLE_CYC_DEF
) (
  input wire logic core_clk_in, // 10 MHz core clock
  input wire logic rst_in, // sync reset, active high
  input wire logic [7:0] reg_addr_in, // register byte address
  input wire logic [31:0] reg_wdata_in, // register write data
  input wire logic reg_wr_in, // write strobe
  input wire logic reg_rd_in, // read strobe
  input wire logic xtal32m_stable_in, // fast crystal reports stable
  input wire logic slow_xtal_stable_in, // slow crystal stability detector
  input wire logic sleep_in, // high while asleep
  output logic [31:0] reg_rdata_out, // read data, cycle after strobe
  output logic sys_clk_src_is_rc_out, // system source in use, 1 = rc
  output logic xtal32m_pwr_en_out, // fast crystal power enable
  output logic cpu_clk_en_out, // cpu clock enable pulse
  output logic periph_clk_en_out, // peripheral clock enable pulse
  output logic [1:0] slow_src_active_out, // slow source driving the slow clock
  output logic slow_xtal_en_out, // slow crystal oscillator enable
  output logic slow_xtal_pin_a_input_out, // force pin a to input, pull-up off
  output logic slow_xtal_pin_b_input_out, // force pin b to input, pull-up off
  output logic [2:0] slow_rc_current_trim_out // external slow rc current trim
);
  // register access decode
  logic wr_ctrl;
  logic wr_slow;
  logic wr_trim;
  logic wr_div;
  assign wr_ctrl = reg_wr_in && (reg_addr_in == sscs_pkg::OFF_SYS_CTRL);
  assign wr_slow = reg_wr_in && (reg_addr_in == sscs_pkg::OFF_SLOW_SEL);
  assign wr_trim = reg_wr_in && (reg_addr_in == sscs_pkg::OFF_SLOW_TRIM);
  assign wr_div = reg_wr_in && (reg_addr_in == sscs_pkg::OFF_CPU_DIV);

  // wake is the falling edge of the sleep level
  logic sleep_q;
  logic wake;
  assign wake = sleep_q && !sleep_in;

  // system source control state
  logic sys_clk_src_is_rc;
  logic crystal_power_down_opt;
  logic auto_switch;
  logic [2:0] cpu_clk_div_code;
  logic div_fail;
  logic next_src_is_rc;
  logic next_pd_opt;
  logic next_auto_switch;
  logic [2:0] next_div_code;
  logic next_div_fail;

  // software settings; wake forces divisor and auto switch request
  always_comb begin
    next_src_is_rc = sys_clk_src_is_rc;
    next_pd_opt = crystal_power_down_opt;
    next_auto_switch = auto_switch;
    next_div_code = cpu_clk_div_code;
    next_div_fail = div_fail;
    if (wr_ctrl) begin
      next_src_is_rc = reg_wdata_in[sscs_pkg::BIT_SRC_IS_RC];
      next_pd_opt = reg_wdata_in[sscs_pkg::BIT_PWR_DOWN_OPT];
      next_auto_switch = reg_wdata_in[sscs_pkg::BIT_AUTO_SWITCH];
    end
    if (wr_div) begin
      if (sscs_pkg::div_code_valid(reg_wdata_in[2:0])) begin
        next_div_code = reg_wdata_in[2:0];
        next_div_fail = 1'b0;
      end else begin
        next_div_fail = 1'b1; // old code stays
      end
    end
    if (wake) begin
      next_div_code = sscs_pkg::DIV_CODE_BY2;
      if (auto_switch) begin
        next_src_is_rc = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sleep_q <= 1'b0;
      sys_clk_src_is_rc <= 1'b0; // crystal wanted after reset
      crystal_power_down_opt <= 1'b0;
      auto_switch <= 1'b1;
      cpu_clk_div_code <= sscs_pkg::DIV_CODE_BY2;
      div_fail <= 1'b0;
    end else begin
      sleep_q <= sleep_in;
      sys_clk_src_is_rc <= next_src_is_rc;
      crystal_power_down_opt <= next_pd_opt;
      auto_switch <= next_auto_switch;
      cpu_clk_div_code <= next_div_code;
      div_fail <= next_div_fail;
    end
  end

  // fast crystal power and source switch sequencing
  sscs_pkg::sscs_src_state_t src_state;
  sscs_pkg::sscs_src_state_t next_src_state;
  logic [sscs_pkg::CNT_W-1:0] settle_cnt;
  logic [sscs_pkg::CNT_W-1:0] next_settle_cnt;
  logic xtal_ok;
  logic next_pwr_en;
  assign xtal_ok = xtal32m_pwr_en_out && xtal32m_stable_in &&
                   (settle_cnt >= sscs_pkg::CNT_W'(XTAL_SETTLE_CYC));

  // the crystal is dropped when rc is wanted or the device sleeps
  always_comb begin
    next_src_state = src_state;
    unique case (src_state)
      sscs_pkg::SRC_ON_RC: begin
        if (!sys_clk_src_is_rc && !sleep_in) begin
          next_src_state = sscs_pkg::SRC_WAIT_XTAL;
        end
      end
      sscs_pkg::SRC_WAIT_XTAL: begin
        if (sys_clk_src_is_rc || sleep_in) begin
          next_src_state = sscs_pkg::SRC_ON_RC;
        end else if (xtal_ok) begin
          next_src_state = sscs_pkg::SRC_ON_XTAL;
        end
      end
      sscs_pkg::SRC_ON_XTAL: begin
        if (sys_clk_src_is_rc || sleep_in) begin
          next_src_state = sscs_pkg::SRC_ON_RC;
        end
      end
      default: next_src_state = sscs_pkg::SRC_ON_RC;
    endcase
    // off only with rc and the option set, always off asleep
    next_pwr_en = !sleep_in && ((next_src_state != sscs_pkg::SRC_ON_RC) || !crystal_power_down_opt);
    next_settle_cnt = settle_cnt;
    if (!xtal32m_pwr_en_out) begin
      next_settle_cnt = '0;
    end else if (settle_cnt < sscs_pkg::CNT_W'(XTAL_SETTLE_CYC)) begin
      next_settle_cnt = settle_cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      src_state <= sscs_pkg::SRC_ON_RC; // start on rc, crystal warms up
      settle_cnt <= '0;
      xtal32m_pwr_en_out <= 1'b0;
    end else begin
      src_state <= next_src_state;
      settle_cnt <= next_settle_cnt;
      xtal32m_pwr_en_out <= next_pwr_en;
    end
  end

  // divider applies source and divisor only at whole periods
  sscs_cpu_div u_cpu_div (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .src_is_rc_in(src_state != sscs_pkg::SRC_ON_XTAL),
    .div_code_in(cpu_clk_div_code),
    .src_is_rc_out(sys_clk_src_is_rc_out),
    .cpu_clk_en_out(cpu_clk_en_out),
    .periph_clk_en_out(periph_clk_en_out)
  );

  // slow clock source selection
  logic [1:0] slow_src_sel;
  logic slow_fail;
  logic slow_timeout;
  logic [sscs_pkg::CNT_W-1:0] slow_cnt;
  logic [1:0] next_slow_sel;
  logic [1:0] next_slow_active;
  logic next_slow_fail;
  logic next_slow_timeout;
  logic [sscs_pkg::CNT_W-1:0] next_slow_cnt;
  logic [2:0] next_trim;
  logic next_xtal_sel;
  logic slow_ready;
  assign slow_ready = (slow_src_active_out == slow_src_sel);

  // no path leads back to the internal rc once left
  always_comb begin
    next_slow_sel = slow_src_sel;
    next_slow_fail = slow_fail;
    if (wr_slow) begin
      if ((reg_wdata_in[1:0] == sscs_pkg::SLOW_SRC_EXT_RC_MODULE) ||
          (reg_wdata_in[1:0] == sscs_pkg::SLOW_SRC_EXT_CRYSTAL)) begin
        next_slow_sel = reg_wdata_in[1:0];
        next_slow_fail = 1'b0;
      end else begin
        next_slow_fail = 1'b1; // internal rc refused
      end
    end
    next_xtal_sel = (next_slow_sel == sscs_pkg::SLOW_SRC_EXT_CRYSTAL);
    // crystal takes over only on detector word; prior source keeps running
    next_slow_active = slow_src_active_out;
    if (slow_src_sel != sscs_pkg::SLOW_SRC_EXT_CRYSTAL) begin
      next_slow_active = slow_src_sel;
    end else if (slow_xtal_stable_in) begin
      next_slow_active = sscs_pkg::SLOW_SRC_EXT_CRYSTAL;
    end
    // settle watch, flags a crystal that misses its settle window
    next_slow_cnt = '0;
    next_slow_timeout = 1'b0;
    if (slow_xtal_en_out && !slow_ready) begin
      next_slow_timeout = slow_timeout;
      next_slow_cnt = slow_cnt;
      if (slow_cnt >= sscs_pkg::CNT_W'(SLOW_XTAL_WAIT_CYC)) begin
        next_slow_timeout = 1'b1;
      end else begin
        next_slow_cnt = slow_cnt + 1'b1;
      end
    end
    next_trim = slow_rc_current_trim_out;
    if (wr_trim && ((reg_wdata_in[2:0] == sscs_pkg::TRIM_0U53) ||
                    (reg_wdata_in[2:0] == sscs_pkg::TRIM_0U35))) begin
      next_trim = reg_wdata_in[2:0]; // other codes change nothing
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      slow_src_sel <= sscs_pkg::SLOW_SRC_INT_RC;
      slow_src_active_out <= sscs_pkg::SLOW_SRC_INT_RC;
      slow_fail <= 1'b0;
      slow_timeout <= 1'b0;
      slow_cnt <= '0;
      slow_xtal_en_out <= 1'b0;
      slow_xtal_pin_a_input_out <= 1'b0;
      slow_xtal_pin_b_input_out <= 1'b0;
      slow_rc_current_trim_out <= sscs_pkg::TRIM_0U53;
    end else begin
      slow_src_sel <= next_slow_sel;
      slow_src_active_out <= next_slow_active;
      slow_fail <= next_slow_fail;
      slow_timeout <= next_slow_timeout;
      slow_cnt <= next_slow_cnt;
      slow_xtal_en_out <= next_xtal_sel;
      slow_xtal_pin_a_input_out <= next_xtal_sel;
      slow_xtal_pin_b_input_out <= next_xtal_sel;
      slow_rc_current_trim_out <= next_trim;
    end
  end

  // read mux; unmapped addresses and idle cycles read zero
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        sscs_pkg::OFF_SYS_CTRL: begin
          next_rdata[sscs_pkg::BIT_SRC_IS_RC] = sys_clk_src_is_rc;
          next_rdata[sscs_pkg::BIT_PWR_DOWN_OPT] = crystal_power_down_opt;
          next_rdata[sscs_pkg::BIT_AUTO_SWITCH] = auto_switch;
        end
        sscs_pkg::OFF_SLOW_SEL: next_rdata[1:0] = slow_src_sel;
        sscs_pkg::OFF_SLOW_TRIM: next_rdata[2:0] = slow_rc_current_trim_out;
        sscs_pkg::OFF_CPU_DIV: next_rdata[2:0] = cpu_clk_div_code;
        sscs_pkg::OFF_STATUS: begin
          next_rdata[sscs_pkg::BIT_ST_SRC_IS_RC] = sys_clk_src_is_rc_out;
          next_rdata[sscs_pkg::BIT_ST_XTAL_STABLE] = xtal_ok;
          next_rdata[sscs_pkg::BIT_ST_SLOW_FAIL] = slow_fail;
          next_rdata[sscs_pkg::BIT_ST_DIV_FAIL] = div_fail;
          next_rdata[sscs_pkg::BIT_ST_SLOW_TIMEOUT] = slow_timeout;
          next_rdata[sscs_pkg::BIT_ST_SLOW_READY] = slow_ready;
        end
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end
endmodule

/* File: dv/sscs_ctrl_props.sv */
/*
  concurrent checks on the ports of the clock select block.
  assumes the block is bound by the bind below and runs on one clock domain.
*/
`timescale 1ns/10ps
module sscs_ctrl_props #(
  parameter int unsigned SLOW_XTAL_WAIT_CYC = 50,
  parameter int unsigned XTAL_SETTLE_CYC = 5
) (
  input wire logic core_clk_in, // core clock
  input wire logic rst_in, // sync reset
  input wire logic reg_rd_in, // read strobe
  input wire logic sleep_in, // sleep level
  input wire logic xtal32m_stable_in, // fast crystal stable
  input wire logic slow_xtal_stable_in, // slow crystal stable
  input wire logic [31:0] reg_rdata_out, // read data
  input wire logic sys_clk_src_is_rc_out, // applied source
  input wire logic xtal32m_pwr_en_out, // crystal power
  input wire logic cpu_clk_en_out, // cpu pulse
  input wire logic periph_clk_en_out, // peripheral pulse
  input wire logic [1:0] slow_src_active_out, // slow source
  input wire logic slow_xtal_en_out, // slow crystal enable
  input wire logic slow_xtal_pin_a_input_out, // pin a input
  input wire logic slow_xtal_pin_b_input_out, // pin b input
  input wire logic [2:0] slow_rc_current_trim_out // trim
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  logic [5:0] gap_cnt;
  logic [5:0] next_gap_cnt;
  logic seen;
  logic next_seen;
  // cycles since last cpu pulse; sleep may stop the cpu so history is dropped
  always_comb begin
    next_gap_cnt = cpu_clk_en_out ? 6'h01 : ((gap_cnt == 6'h3f) ? gap_cnt : gap_cnt + 6'h01);
    next_seen = (seen | cpu_clk_en_out) & ~sleep_in;
  end
  always_ff @(posedge core_clk_in) begin
    gap_cnt <= rst_in ? 6'h00 : next_gap_cnt;
    seen <= rst_in ? 1'b0 : next_seen;
  end
  property p_rdata_idle; !$past(reg_rd_in) |-> reg_rdata_out == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_periph; periph_clk_en_out |=> !periph_clk_en_out; endproperty
  a_periph: assert property (p_periph) else $error("peripheral enable high twice");
  property p_periph_low; (!periph_clk_en_out && !$past(rst_in)) |=> periph_clk_en_out; endproperty
  a_periph_low: assert property (p_periph_low) else $error("peripheral enable low twice");
  property p_cpu_gap; (cpu_clk_en_out && seen) |-> gap_cnt inside {6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20}; endproperty
  a_cpu_gap: assert property (p_cpu_gap) else $error("cpu period not a legal ratio");
  property p_src_edge; $changed(sys_clk_src_is_rc_out) |-> cpu_clk_en_out; endproperty
  a_src_edge: assert property (p_src_edge) else $error("source switched mid period");
  property p_xtal_ok; $fell(sys_clk_src_is_rc_out) |-> $past(xtal32m_stable_in) && $past(xtal32m_pwr_en_out); endproperty
  a_xtal_ok: assert property (p_xtal_ok) else $error("switch to unstable crystal");
  property p_sleep_pwr; sleep_in |=> !xtal32m_pwr_en_out; endproperty
  a_sleep_pwr: assert property (p_sleep_pwr) else $error("crystal powered in sleep");
  property p_pins; slow_xtal_en_out |-> slow_xtal_pin_a_input_out && slow_xtal_pin_b_input_out; endproperty
  a_pins: assert property (p_pins) else $error("slow crystal pins not input");
  property p_slow_ready; ($changed(slow_src_active_out) && slow_src_active_out == 2'h2) |-> $past(slow_xtal_stable_in); endproperty
  a_slow_ready: assert property (p_slow_ready) else $error("slow crystal used unconfirmed");
  property p_no_back; slow_src_active_out != 2'h0 |=> slow_src_active_out != 2'h0; endproperty
  a_no_back: assert property (p_no_back) else $error("slow clock back on internal rc");
  property p_trim; slow_rc_current_trim_out inside {3'h2, 3'h3}; endproperty
  a_trim: assert property (p_trim) else $error("trim holds a reserved code");
endmodule
bind sscs_ctrl sscs_ctrl_props #(.SLOW_XTAL_WAIT_CYC(SLOW_XTAL_WAIT_CYC), .XTAL_SETTLE_CYC(XTAL_SETTLE_CYC)) i_sscs_ctrl_props (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_rd_in(reg_rd_in), .sleep_in(sleep_in),
  .xtal32m_stable_in(xtal32m_stable_in), .slow_xtal_stable_in(slow_xtal_stable_in), .reg_rdata_out(reg_rdata_out),
  .sys_clk_src_is_rc_out(sys_clk_src_is_rc_out), .xtal32m_pwr_en_out(xtal32m_pwr_en_out),
  .cpu_clk_en_out(cpu_clk_en_out), .periph_clk_en_out(periph_clk_en_out), .slow_src_active_out(slow_src_active_out),
  .slow_xtal_en_out(slow_xtal_en_out), .slow_xtal_pin_a_input_out(slow_xtal_pin_a_input_out),
  .slow_xtal_pin_b_input_out(slow_xtal_pin_b_input_out), .slow_rc_current_trim_out(slow_rc_current_trim_out));

/* File: dv/sscs_osc_model.sv */
/*
  behavioural fast and slow crystal oscillators with stability outputs.
  assumes enables come from the block, synchronous to the core clock.
*/
`timescale 1ns/10ps
module sscs_osc_model #(
  parameter int unsigned FAST_CYC = 3,
  parameter int unsigned SLOW_CYC = 20
) (
  input wire logic core_clk_in, // core clock
  input wire logic rst_in, // sync reset
  input wire logic xtal_pwr_en_in, // fast crystal power
  input wire logic slow_en_in, // slow crystal enable
  input wire logic slow_block_in, // slow crystal never settles
  output logic xtal_stable_out, // fast crystal stable
  output logic slow_stable_out // slow crystal stable
);
  int unsigned fast_cnt;
  int unsigned slow_cnt;
  // stability drops at once when power goes, so a stale level never lingers
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !xtal_pwr_en_in) begin
      fast_cnt <= 0;
      xtal_stable_out <= 1'b0;
    end else if (fast_cnt < FAST_CYC) begin
      fast_cnt <= fast_cnt + 1;
    end else begin
      xtal_stable_out <= 1'b1;
    end
    if (rst_in || !slow_en_in || slow_block_in) begin
      slow_cnt <= 0;
      slow_stable_out <= 1'b0;
    end else if (slow_cnt < SLOW_CYC) begin
      slow_cnt <= slow_cnt + 1;
    end else begin
      slow_stable_out <= 1'b1;
    end
  end
endmodule

/* File: dv/tb.sv */
/*
  self-checking bench for the clock select block through its register port.
  assumes the oscillator model stands in for both crystals.
*/
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sleep = 1'b0;
  logic block = 1'b0;
  logic fast_ok, slow_ok, src_rc, pwr_en, cpu_en, per_en, xen, pin_a, pin_b;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [1:0] slow_act;
  logic [2:0] trim;
  logic [2:0] exp_code;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  int g;
  int ratio_of[8] = '{8, 4, 2, 1, 0, 0, 32, 16};
  // 100 ns core clock
  always #50 clk = ~clk;
  sscs_ctrl #(.SLOW_XTAL_WAIT_CYC(50), .XTAL_SETTLE_CYC(5)) i_sscs_ctrl (
    .core_clk_in(clk), .rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .xtal32m_stable_in(fast_ok), .slow_xtal_stable_in(slow_ok), .sleep_in(sleep), .reg_rdata_out(rdata),
    .sys_clk_src_is_rc_out(src_rc), .xtal32m_pwr_en_out(pwr_en), .cpu_clk_en_out(cpu_en),
    .periph_clk_en_out(per_en), .slow_src_active_out(slow_act), .slow_xtal_en_out(xen),
    .slow_xtal_pin_a_input_out(pin_a), .slow_xtal_pin_b_input_out(pin_b), .slow_rc_current_trim_out(trim));
  sscs_osc_model i_sscs_osc_model (.core_clk_in(clk), .rst_in(rst), .xtal_pwr_en_in(pwr_en), .slow_en_in(xen),
    .slow_block_in(block), .xtal_stable_out(fast_ok), .slow_stable_out(slow_ok));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // strobes rise after an edge and are taken at the next one
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic wait_src(input logic v);
    for (int n = 0; n < 300 && src_rc !== v; n++) @(posedge clk);
    #1 check({31'h0, src_rc}, {31'h0, v});
  endtask
  // cycles between two cpu pulses
  task automatic cpu_gap(output int gp);
    for (int n = 0; n < 100 && cpu_en !== 1'b1; n++) begin @(posedge clk); #1; end
    @(posedge clk);
    #1 gp = 1;
    while (cpu_en !== 1'b1 && gp < 100) begin @(posedge clk); #1 gp++; end
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 check({29'h0, trim}, 32'h2);
    check({30'h0, slow_act}, 32'h0);
    reg_rd(sscs_pkg::OFF_SYS_CTRL, d);
    check(d, 32'h4);
    reg_rd(8'h20, d);
    check(d, 32'h0);
    wait_src(1'b0);
    reg_rd(sscs_pkg::OFF_STATUS, d);
    check(d[1:0], 2'h2);
    exp_code = sscs_pkg::DIV_CODE_BY2;
    for (int c = 0; c < 8; c++) begin
      if (ratio_of[c] != 0) exp_code = 3'(c);
      reg_wr(sscs_pkg::OFF_CPU_DIV, 32'(c));
      reg_rd(sscs_pkg::OFF_CPU_DIV, d);
      check(d, {29'h0, exp_code});
      reg_rd(sscs_pkg::OFF_STATUS, d);
      check(d[3], ratio_of[c] == 0);
      cpu_gap(g);
      cpu_gap(g);
      check(32'(g), 32'(ratio_of[exp_code]));
    end
    reg_wr(sscs_pkg::OFF_SYS_CTRL, 32'h5);
    wait_src(1'b1);
    check({31'h0, pwr_en}, 32'h1);
    reg_wr(sscs_pkg::OFF_SYS_CTRL, 32'h7);
    repeat (3) @(posedge clk);
    #1 check({31'h0, pwr_en}, 32'h0);
    reg_rd(sscs_pkg::OFF_STATUS, d);
    check(d[1:0], 2'h1);
    reg_wr(sscs_pkg::OFF_SYS_CTRL, 32'h4);
    wait_src(1'b0);
    reg_wr(sscs_pkg::OFF_CPU_DIV, 32'h6);
    reg_wr(sscs_pkg::OFF_SYS_CTRL, 32'h5);
    sleep <= 1'b1;
    wait_src(1'b1);
    check({31'h0, pwr_en}, 32'h0);
    @(posedge clk);
    sleep <= 1'b0;
    reg_rd(sscs_pkg::OFF_CPU_DIV, d);
    check(d, 32'h2);
    wait_src(1'b0);
    exp_code = 3'h2;
    foreach (ratio_of[c]) begin
      reg_wr(sscs_pkg::OFF_SLOW_TRIM, 32'(c));
      if (c == 2 || c == 3) exp_code = 3'(c);
      reg_rd(sscs_pkg::OFF_SLOW_TRIM, d);
      check(d, {29'h0, exp_code});
      check({29'h0, trim}, {29'h0, exp_code});
    end
    for (int c = 0; c < 4; c += 3) begin
      reg_wr(sscs_pkg::OFF_SLOW_SEL, 32'(c));
      reg_rd(sscs_pkg::OFF_STATUS, d);
      check(d[2], 1'b1);
    end
    reg_wr(sscs_pkg::OFF_SLOW_SEL, 32'h2);
    #1 check({29'h0, xen, pin_a, pin_b}, 32'h7);
    reg_rd(sscs_pkg::OFF_STATUS, d);
    check({d[10], d[2]}, 2'h0);
    check({30'h0, slow_act}, 32'h0);
    for (int n = 0; n < 100 && slow_act !== 2'h2; n++) @(posedge clk);
    #1 check({30'h0, slow_act}, 32'h2);
    reg_rd(sscs_pkg::OFF_STATUS, d);
    check(d[10], 1'b1);
    reg_wr(sscs_pkg::OFF_SLOW_SEL, 32'h0);
    repeat (3) @(posedge clk);
    #1 check({30'h0, slow_act}, 32'h2);
    do_reset();
    check({30'h0, slow_act}, 32'h0);
    block <= 1'b1;
    reg_wr(sscs_pkg::OFF_SLOW_SEL, 32'h1);
    repeat (2) @(posedge clk);
    #1 check({30'h0, slow_act}, 32'h1);
    reg_wr(sscs_pkg::OFF_SLOW_SEL, 32'h2);
    repeat (60) @(posedge clk);
    reg_rd(sscs_pkg::OFF_STATUS, d);
    check({d[10], d[4]}, 2'h1);
    check({30'h0, slow_act}, 32'h1);
    give_verdict();
  end
endmodule
